// [sfsp_top.sv]
/*
 * Status register, block protection and pause control of a serial
 * flash. Link side runs on SPI_SCK (mode 0/3) with SPI_CS_N as frame
 * reset; control side runs on CLK. The program/erase engine sits
 * outside: it takes OP_REQ with OP_START and answers OP_DONE on CLK.
 * Assumes SPI_CS_N is high at power-up and SCK is quiet while deselected.
 */
`timescale 1ns/10ps
`default_nettype none

`include "sfsp_consts.svh"

module sfsp_top
    import sfsp_pkg::*;
#(
    parameter logic [7:0] WRITE_ENABLE_OPCODE  = 8'h06,
    parameter logic [7:0] WRITE_DISABLE_OPCODE = 8'h04
) (
    input  wire logic         CLK,
    input  wire logic         RESET_N,
    input  wire logic         SPI_SCK,
    input  wire logic         SPI_CS_N,
    input  wire logic         SPI_SI,
    output logic              SPI_SO,
    output logic              SPI_SO_OE,
    input  wire logic         WP_N,
    input  wire logic         HOLD_N,
    output var sfsp_req_t     OP_REQ,
    output logic              OP_START,
    input  wire logic         OP_DONE,
    output var sfsp_status_t  STATUS
);

    ////////////////////////////////////////////////////////////////////
    // Protection decode

    function automatic logic [20:0] level_base(input logic [2:0] level);
        logic [20:0] base;
        base = `SFSP_BASE_ALL;
        case (level)
            3'h0: base = `SFSP_BASE_NONE;
            3'h1: base = `SFSP_BASE_UPPER16;
            3'h2: base = `SFSP_BASE_UPPER8;
            3'h3: base = `SFSP_BASE_UPPER4;
            3'h4: base = `SFSP_BASE_UPPER2;
            default: base = `SFSP_BASE_ALL;
        endcase
        return base;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Link domain, rising edge

    logic        first_reg;
    logic        frame_tog_reg;
    logic [11:0] bit_cnt_reg;
    logic [11:0] bit_cnt_next;
    logic [23:0] shift_reg;
    logic [23:0] shift_next;
    logic [7:0]  op_reg;
    logic [19:0] addr_reg;
    logic [7:0]  data_reg;
    logic [7:0]  st_l1_reg;
    logic [7:0]  st_l2_reg;
    logic        link_take;
    logic        link_rst_reg;
    sfsp_status_t st_reg;

    // Hold low at the rising edge means the bit is not taken
    assign link_take = HOLD_N;

    assign shift_next = {shift_reg[22:0], SPI_SI};

    assign bit_cnt_next = first_reg ? 12'h001 :
                          (bit_cnt_reg == `SFSP_LEN_MAX) ? bit_cnt_reg :
                          bit_cnt_reg + 12'h001;

    // Select high clears the frame state without any clock edge
    always_ff @(posedge SPI_SCK or posedge SPI_CS_N) begin
        if (SPI_CS_N) begin
            first_reg <= 1'b1;
        end else if (link_take) begin
            first_reg <= 1'b0;
        end
    end

    // Toggle needs a known start, or every frame end stays unknown
    always_ff @(posedge SPI_SCK or posedge link_rst_reg) begin
        if (link_rst_reg) begin
            frame_tog_reg <= 1'b0;
        end else if (link_take && first_reg) begin
            frame_tog_reg <= ~frame_tog_reg;
        end
    end

    always_ff @(posedge SPI_SCK) begin
        if (link_take) begin
            bit_cnt_reg <= bit_cnt_next;
            shift_reg   <= shift_next;
        end
    end

    always_ff @(posedge SPI_SCK) begin
        if (link_take && bit_cnt_next == `SFSP_LEN_OPCODE) begin
            op_reg <= shift_next[7:0];
        end
    end

    always_ff @(posedge SPI_SCK) begin
        if (link_take && bit_cnt_next == `SFSP_LEN_ADDR) begin
            addr_reg <= shift_next[19:0];
        end
    end

    always_ff @(posedge SPI_SCK) begin
        if (link_take && bit_cnt_next == `SFSP_LEN_STATUS_WRITE) begin
            data_reg <= shift_next[7:0];
        end
    end

    // Status bits are independent flags, so each crosses as a level
    always_ff @(posedge SPI_SCK) begin
        st_l1_reg <= st_reg;
        st_l2_reg <= st_l1_reg;
    end

    ////////////////////////////////////////////////////////////////////
    // Link domain, falling edge

    logic so_reg;
    logic so_oe_reg;
    logic reading;

    assign reading = !first_reg && (op_reg == `SFSP_OP_STATUS_READ)
                     && (bit_cnt_reg >= `SFSP_LEN_OPCODE);

    // Hold floats the pin at once; driving resumes only at the next
    // falling edge, so a host should release hold during a high phase
    always_ff @(negedge SPI_SCK or posedge SPI_CS_N or negedge HOLD_N) begin
        if (SPI_CS_N || !HOLD_N) begin
            so_oe_reg <= 1'b0;
        end else begin
            so_oe_reg <= reading;
        end
    end

    // Status repeats while the clock runs until the bit count saturates; then bit 0 repeats
    always_ff @(negedge SPI_SCK) begin
        if (HOLD_N) begin
            so_reg <= st_l2_reg[~bit_cnt_reg[2:0]];
        end
    end

    assign SPI_SO    = so_reg;
    assign SPI_SO_OE = so_oe_reg;

    ////////////////////////////////////////////////////////////////////
    // Control domain synchronisers

    logic cs_s1_reg;
    logic cs_s2_reg;
    logic cs_s3_reg;
    logic tog_s1_reg;
    logic tog_s2_reg;
    logic wp_s1_reg;
    logic wp_s2_reg;
    logic seen_reg;
    logic frame_end;

    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            cs_s1_reg  <= 1'b1;
            cs_s2_reg  <= 1'b1;
            cs_s3_reg  <= 1'b1;
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
            wp_s1_reg  <= 1'b0;
            wp_s2_reg  <= 1'b0;
            link_rst_reg <= 1'b1;
        end else begin
            cs_s1_reg  <= SPI_CS_N;
            cs_s2_reg  <= cs_s1_reg;
            cs_s3_reg  <= cs_s2_reg;
            tog_s1_reg <= frame_tog_reg;
            tog_s2_reg <= tog_s1_reg;
            wp_s1_reg  <= WP_N;
            wp_s2_reg  <= wp_s1_reg;
            link_rst_reg <= 1'b0;
        end
    end

    // Frame words are stable once select has risen, so they are read
    // only behind the synchronised rising edge of select
    assign frame_end = cs_s2_reg && !cs_s3_reg && (tog_s2_reg != seen_reg);

    ////////////////////////////////////////////////////////////////////
    // Command decode

    logic        is_write_enable_cmd;
    logic        is_write_disable_cmd;
    logic        is_ewsr;
    logic        status_write_cmd;
    logic        is_page;
    logic        is_sector;
    logic        is_block;
    logic        is_chip;
    logic        is_auto_first;
    logic        is_auto_next;
    logic [2:0]  level;
    logic [20:0] base;
    logic        addr_ok;
    logic        auto_ok;
    logic [20:0] auto_sum;
    logic        auto_limit;
    logic [20:0] auto_addr_reg;
    logic [20:0] auto_addr_next;
    logic        ewsr_reg;
    logic        ewsr_next;

    assign is_write_enable_cmd = (op_reg == WRITE_ENABLE_OPCODE)
                     && (bit_cnt_reg == `SFSP_LEN_OPCODE);
    assign is_write_disable_cmd = (op_reg == WRITE_DISABLE_OPCODE)
                     && (bit_cnt_reg == `SFSP_LEN_OPCODE);
    assign is_ewsr = (op_reg == `SFSP_OP_ENABLE_STATUS)
                     && (bit_cnt_reg == `SFSP_LEN_OPCODE);
    assign status_write_cmd = (op_reg == `SFSP_OP_STATUS_WRITE)
                     && (bit_cnt_reg == `SFSP_LEN_STATUS_WRITE);
    assign is_page = (op_reg == `SFSP_OP_PAGE_PROG)
                     && (bit_cnt_reg >= `SFSP_LEN_PAGE_MIN)
                     && (bit_cnt_reg[2:0] == 3'h0);
    assign is_sector = (op_reg == `SFSP_OP_SECTOR_ERASE)
                     && (bit_cnt_reg == `SFSP_LEN_ADDR);
    assign is_block = (op_reg == `SFSP_OP_BLOCK_ERASE)
                     && (bit_cnt_reg == `SFSP_LEN_ADDR);
    assign is_chip = ((op_reg == `SFSP_OP_CHIP_ERASE_A)
                     || (op_reg == `SFSP_OP_CHIP_ERASE_B))
                     && (bit_cnt_reg == `SFSP_LEN_OPCODE);
    assign is_auto_first = (op_reg == `SFSP_OP_AUTO_INC)
                     && (bit_cnt_reg == `SFSP_LEN_AUTO_FIRST)
                     && !st_reg.auto_increment_program_mode;
    assign is_auto_next = (op_reg == `SFSP_OP_AUTO_INC)
                     && (bit_cnt_reg == `SFSP_LEN_AUTO_NEXT)
                     && st_reg.auto_increment_program_mode;

    assign level = {st_reg.protect_level_bit2, st_reg.protect_level_bit1,
                    st_reg.protect_level_bit0};
    assign base = level_base(level);

    assign addr_ok  = {1'b0, addr_reg} < base;
    assign auto_ok  = auto_addr_reg < level_base(level);
    assign auto_sum = auto_addr_reg + `SFSP_AUTO_STEP;
    assign auto_limit = auto_sum >= base;

    ////////////////////////////////////////////////////////////////////
    // Request selection

    logic       start_page;
    logic       start_sector;
    logic       start_block;
    logic       start_chip;
    logic       start_first;
    logic       start_next;
    logic       go;
    sfsp_req_t  req_reg;
    sfsp_req_t  req_next;
    logic       start_reg;

    assign start_page   = is_page && addr_ok;
    assign start_sector = is_sector && addr_ok;
    assign start_block  = is_block && addr_ok;
    assign start_chip   = is_chip && (level == 3'h0);
    assign start_first  = is_auto_first && addr_ok;
    assign start_next   = is_auto_next && auto_ok;

    // Busy drops every frame but status reads, which need no decode
    assign go = frame_end && !st_reg.busy
                && st_reg.write_enable_latch
                && (start_page || start_sector || start_block
                    || start_chip || start_first || start_next);

    always_comb begin
        req_next = req_reg;
        if (go) begin
            req_next.addr = addr_reg;
            if (start_page) begin
                req_next.kind = SFSP_KIND_PAGE;
            end else if (start_sector) begin
                req_next.kind = SFSP_KIND_SECTOR;
            end else if (start_block) begin
                req_next.kind = SFSP_KIND_BLOCK;
            end else if (start_chip) begin
                req_next.kind = SFSP_KIND_CHIP;
            end else if (start_first) begin
                req_next.kind = SFSP_KIND_AUTO_WORD;
            end else begin
                req_next.kind = SFSP_KIND_AUTO_WORD;
                req_next.addr = auto_addr_reg[19:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status next value

    sfsp_status_t st_next;

    always_comb begin
        st_next        = st_reg;
        auto_addr_next = auto_addr_reg;
        ewsr_next      = ewsr_reg;
        if (st_reg.busy && OP_DONE) begin
            st_next.busy = 1'b0;
            if (req_reg.kind != SFSP_KIND_AUTO_WORD) begin
                st_next.write_enable_latch = 1'b0;
            end else begin
                auto_addr_next = auto_sum;
                if (auto_limit) begin
                    st_next.auto_increment_program_mode = 1'b0;
                    st_next.write_enable_latch = 1'b0;
                end
            end
        end else if (frame_end && !st_reg.busy) begin
            ewsr_next = is_ewsr;
            if (is_write_enable_cmd) begin
                st_next.write_enable_latch = 1'b1;
            end
            if (is_write_disable_cmd) begin
                st_next.write_enable_latch = 1'b0;
                st_next.auto_increment_program_mode = 1'b0;
            end
            if (status_write_cmd) begin
                st_next.write_enable_latch = 1'b0;
                // Only level and lock-down bits take the written value
                if ((st_reg.write_enable_latch || ewsr_reg)
                    && (wp_s2_reg || !st_reg.protect_lockdown)) begin
                    st_next.protect_level_bit0 = data_reg[`SFSP_BIT_LEVEL0];
                    st_next.protect_level_bit1 = data_reg[`SFSP_BIT_LEVEL0 + 1];
                    st_next.protect_level_bit2 = data_reg[`SFSP_BIT_LEVEL2];
                    st_next.protect_lockdown   = data_reg[`SFSP_BIT_LOCKDOWN];
                end
            end
            if (go) begin
                st_next.busy = 1'b1;
            end
            if (go && start_first) begin
                st_next.auto_increment_program_mode = 1'b1;
                auto_addr_next = {1'b0, addr_reg};
            end
        end
        st_next.reserved = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Control registers

    // Synchronous reset restores full protection on every power-up
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            st_reg        <= `SFSP_STATUS_RST;
            auto_addr_reg <= 21'h000000;
            ewsr_reg      <= 1'b0;
            seen_reg      <= 1'b0;
            start_reg     <= 1'b0;
            req_reg       <= '0;
        end else begin
            st_reg        <= st_next;
            auto_addr_reg <= auto_addr_next;
            ewsr_reg      <= ewsr_next;
            seen_reg      <= frame_end ? tog_s2_reg : seen_reg;
            start_reg     <= go;
            req_reg       <= req_next;
        end
    end

    assign OP_START = start_reg;
    assign OP_REQ   = req_reg;
    assign STATUS   = st_reg;

endmodule

`default_nettype wire

// [sfsp_consts.svh]
/*
 * Constants of the serial flash status and protection block:
 * status bit positions, reset value, opcodes, frame lengths and
 * protection bases. Assumes a 20-bit byte address (1 MiB array).
 */
`ifndef SFSP_CONSTS_SVH
`define SFSP_CONSTS_SVH

`define SFSP_BIT_BUSY          0
`define SFSP_BIT_WRITE_EN      1
`define SFSP_BIT_LEVEL0        2
`define SFSP_BIT_LEVEL2        4
`define SFSP_BIT_LOCKDOWN      7
`define SFSP_STATUS_RST        8'h1C

`define SFSP_OP_STATUS_READ    8'h05
`define SFSP_OP_STATUS_WRITE   8'h01
`define SFSP_OP_ENABLE_STATUS  8'h50
`define SFSP_OP_PAGE_PROG      8'h02
`define SFSP_OP_AUTO_INC       8'hAD
`define SFSP_OP_SECTOR_ERASE   8'h20
`define SFSP_OP_BLOCK_ERASE    8'hD8
`define SFSP_OP_CHIP_ERASE_A   8'h60
`define SFSP_OP_CHIP_ERASE_B   8'hC7

`define SFSP_LEN_OPCODE        12'h008
`define SFSP_LEN_STATUS_WRITE  12'h010
`define SFSP_LEN_ADDR          12'h020
`define SFSP_LEN_PAGE_MIN      12'h028
`define SFSP_LEN_AUTO_FIRST    12'h030
`define SFSP_LEN_AUTO_NEXT     12'h018
`define SFSP_LEN_MAX           12'hFFF

`define SFSP_BASE_NONE         21'h100000
`define SFSP_BASE_UPPER16      21'h0F0000
`define SFSP_BASE_UPPER8       21'h0E0000
`define SFSP_BASE_UPPER4       21'h0C0000
`define SFSP_BASE_UPPER2       21'h080000
`define SFSP_BASE_ALL          21'h000000
`define SFSP_AUTO_STEP         21'h000002

`endif

// [sfsp_pkg.sv]
/*
 * Types of the serial flash status and protection block.
 * Assumes sfsp_consts.svh holds all numeric constants.
 */
package sfsp_pkg;

    typedef enum logic [2:0] {
        SFSP_KIND_NONE,
        SFSP_KIND_PAGE,
        SFSP_KIND_AUTO_WORD,
        SFSP_KIND_SECTOR,
        SFSP_KIND_BLOCK,
        SFSP_KIND_CHIP
    } sfsp_kind_t;

    // Field order matches status bit positions 7 down to 0
    typedef struct packed {
        logic protect_lockdown;
        logic auto_increment_program_mode;
        logic reserved;
        logic protect_level_bit2;
        logic protect_level_bit1;
        logic protect_level_bit0;
        logic write_enable_latch;
        logic busy;
    } sfsp_status_t;

    typedef struct packed {
        sfsp_kind_t  kind;
        logic [19:0] addr;
    } sfsp_req_t;

endpackage

// [sfsp_top_props.sv]
/*
 * Checker on the ports of sfsp_top.
 * Assumes a bind into sfsp_top; CLK and SPI_SCK domains.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sfsp_consts.svh"
module sfsp_top_props
    import sfsp_pkg::*;
(
    input wire logic         CLK,
    input wire logic         RESET_N,
    input wire logic         SPI_SCK,
    input wire logic         SPI_CS_N,
    input wire logic         SPI_SO_OE,
    input wire logic         WP_N,
    input wire logic         HOLD_N,
    input wire sfsp_req_t    OP_REQ,
    input wire logic         OP_START,
    input wire logic         OP_DONE,
    input wire sfsp_status_t STATUS
);
    wire [2:0]  lvl;
    wire [20:0] base;
    assign lvl  = STATUS[4:2];
    assign base = (lvl == 3'h0) ? `SFSP_BASE_NONE : (lvl == 3'h1) ? `SFSP_BASE_UPPER16 :
                  (lvl == 3'h2) ? `SFSP_BASE_UPPER8 : (lvl == 3'h3) ? `SFSP_BASE_UPPER4 :
                  (lvl == 3'h4) ? `SFSP_BASE_UPPER2 : `SFSP_BASE_ALL;

    // Synchroniser on the pin needs a few cycles of low level
    sequence s_locked;
        (!WP_N && STATUS.protect_lockdown) [*4];
    endsequence
    sequence s_done;
        STATUS.busy && OP_DONE && (OP_REQ.kind != SFSP_KIND_AUTO_WORD);
    endsequence

    rst_value_a: assert property (@(posedge CLK) !RESET_N |=> STATUS == `SFSP_STATUS_RST)
        else $error("status not at default after reset");
    reserved_zero_a: assert property (@(posedge CLK) disable iff (!RESET_N) STATUS.reserved == 1'b0)
        else $error("reserved status bit set");
    start_busy_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        OP_START |-> STATUS.busy && !$past(STATUS.busy)) else $error("busy not raised with start");
    start_latch_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        OP_START |-> $past(STATUS.write_enable_latch)) else $error("start without enable latch");
    busy_cause_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        $rose(STATUS.busy) |-> OP_START) else $error("busy rose without start");
    chip_level_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        OP_START && OP_REQ.kind == SFSP_KIND_CHIP |-> lvl == 3'h0) else $error("chip erase while protected");
    range_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        OP_START && OP_REQ.kind != SFSP_KIND_CHIP |-> {1'b0, OP_REQ.addr} < base)
        else $error("start into protected range");
    done_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_done |=> !STATUS.busy && !STATUS.write_enable_latch) else $error("done did not clear busy and latch");
    lock_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_locked |=> $stable({STATUS.protect_lockdown, lvl})) else $error("locked bits changed");
    hold_float_a: assert property (@(posedge SPI_SCK) disable iff (SPI_CS_N)
        !HOLD_N ##1 !HOLD_N |-> !SPI_SO_OE) else $error("output driven while paused");
    deselect_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        SPI_CS_N ##1 SPI_CS_N |-> !SPI_SO_OE) else $error("output driven while deselected");
endmodule

bind sfsp_top sfsp_top_props i_sfsp_top_props (.CLK(CLK), .RESET_N(RESET_N), .SPI_SCK(SPI_SCK),
    .SPI_CS_N(SPI_CS_N), .SPI_SO_OE(SPI_SO_OE), .WP_N(WP_N), .HOLD_N(HOLD_N), .OP_REQ(OP_REQ),
    .OP_START(OP_START), .OP_DONE(OP_DONE), .STATUS(STATUS));
`default_nettype wire

// [sfsp_spi_host.sv]
/*
 * SPI host model, mode 0, with an optional pause mid-frame.
 * Assumes the caller spaces frames; SCK stays low outside frames.
 */
`timescale 1ns/10ps
`default_nettype none
module sfsp_spi_host (
    output logic      SCK,
    output logic      CS_N,
    output logic      SI,
    output logic      HOLD_N,
    input  wire logic SO,
    input  wire logic SO_OE
);
    logic hold_oe;
    initial begin
        SCK = 1'b0;
        SI = 1'b0;
        HOLD_N = 1'b1;
        hold_oe = 1'b0;
        // A real rising select gives the link logic a known frame state
        #1 CS_N = 1'b1;
    end

    // Bits go MSB first; rd keeps the last eight samples of SO
    task automatic frame(input logic [47:0] b, input int n, input int h, output logic [7:0] rd);
        rd = 8'h00;
        hold_oe = 1'b0;
        CS_N = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            if (n - 1 - i == h) begin
                HOLD_N = 1'b0;
                #1 hold_oe = hold_oe | SO_OE;
                for (int k = 0; k < 3; k++) begin
                    SI = ~SI;
                    #62.5 SCK = 1'b1;
                    // Release in the high phase, so SO is driven again at the fall
                    #30 HOLD_N = (k == 2);
                    #32.5 SCK = 1'b0;
                    #5 hold_oe = hold_oe | (SO_OE & ~HOLD_N);
                end
            end
            SI = b[i];
            #62.5 rd = {rd[6:0], SO};
            SCK = 1'b1;
            #62.5 SCK = 1'b0;
        end
        #30 CS_N = 1'b1;
        // Released line must not keep the last bit
        SI = ~SI;
        #200;
    endtask
endmodule
`default_nettype wire

// [sfsp_top_tb.sv]
/*
 * Testbench of sfsp_top with SPI host model and engine stub.
 * Assumes the checker is bound; engine answers by hand.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sfsp_consts.svh"
module sfsp_top_tb
    import sfsp_pkg::*;
;
    localparam logic [7:0] WEN = 8'h06;
    localparam logic [7:0] WDIS = 8'h04;
    logic         clk = 1'b0;
    logic         reset_n = 1'b0;
    logic         wp_n = 1'b1;
    logic         op_done = 1'b0;
    wire          sck, cs_n, si, hold_n, so, so_oe, so_wire, op_start;
    sfsp_req_t    op_req;
    sfsp_status_t status;
    logic [7:0]   rd;
    int           bad_count = 0;
    int           checks = 0;
    int           starts = 0;

    assign so_wire = so_oe ? so : ~so;
    always #4 clk = ~clk;
    always @(posedge clk) if (op_start === 1'b1) starts <= starts + 1;

    sfsp_top #(.WRITE_ENABLE_OPCODE(WEN), .WRITE_DISABLE_OPCODE(WDIS)) i_sfsp_top (.CLK(clk),
        .RESET_N(reset_n), .SPI_SCK(sck), .SPI_CS_N(cs_n), .SPI_SI(si), .SPI_SO(so), .SPI_SO_OE(so_oe),
        .WP_N(wp_n), .HOLD_N(hold_n), .OP_REQ(op_req), .OP_START(op_start), .OP_DONE(op_done), .STATUS(status));
    sfsp_spi_host i_sfsp_spi_host (.SCK(sck), .CS_N(cs_n), .SI(si), .HOLD_N(hold_n), .SO(so_wire), .SO_OE(so_oe));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude;
        if (bad_count == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Ten cycles covers the frame-end synchroniser and decode
    task automatic cmd(input logic [47:0] b, input int n);
        i_sfsp_spi_host.frame(b, n, -1, rd);
        cyc(10);
    endtask
    task automatic rdst(input int h);
        i_sfsp_spi_host.frame(48'h0500, 16, h, rd);
        cyc(10);
    endtask
    task automatic wrst(input logic [7:0] v);
        cmd({40'h0, WEN}, 8);
        cmd({32'h0, `SFSP_OP_STATUS_WRITE, v}, 16);
    endtask
    task automatic pulse_done;
        op_done = 1'b1;
        cyc(1);
        op_done = 1'b0;
        cyc(2);
    endtask
    task automatic done;
        pulse_done();
        check("wel_busy", status[1:0], 2'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check("status", status, `SFSP_STATUS_RST);
        rdst(-1);
        check("read", rd, `SFSP_STATUS_RST);
    endtask
    task automatic t_write;
        cmd({32'h0, `SFSP_OP_STATUS_WRITE, 8'h00}, 16);
        check("nowen", status, `SFSP_STATUS_RST);
        wrst(8'hFF);
        check("mask", status, 8'h9C);
        rdst(11);
        check("held_read", rd, 8'h9C);
        check("held_oe", i_sfsp_spi_host.hold_oe, 1'b0);
    endtask
    task automatic t_lock;
        wp_n = 1'b0;
        cyc(4);
        wrst(8'h00);
        check("locked", status, 8'h9C);
        wp_n = 1'b1;
        cyc(4);
        wrst(8'h00);
        check("unlocked", status, 8'h00);
    endtask
    task automatic t_write_disable_cmd;
        int s;
        cmd({40'h0, WEN}, 8);
        check("wel", status, 8'h02);
        cmd({40'h0, WDIS}, 8);
        check("wdis", status, 8'h00);
        s = starts;
        cmd({8'h0, `SFSP_OP_PAGE_PROG, 24'h000100, 8'hA5}, 40);
        check("nolatch", starts, s);
    endtask
    task automatic t_levels;
        logic [20:0] base [8] = '{`SFSP_BASE_NONE, `SFSP_BASE_UPPER16, `SFSP_BASE_UPPER8, `SFSP_BASE_UPPER4,
                                  `SFSP_BASE_UPPER2, `SFSP_BASE_ALL, `SFSP_BASE_ALL, `SFSP_BASE_ALL};
        logic [20:0] am;
        int s;
        for (int l = 0; l < 8; l++) begin
            wrst({3'h0, l[2:0], 2'h0});
            check("level", status, {3'h0, l[2:0], 2'h0});
            am = base[l] - 21'h1;
            if (base[l] != 21'h0) begin
                s = starts;
                cmd({40'h0, WEN}, 8);
                cmd({16'h0, `SFSP_OP_SECTOR_ERASE, 4'h0, am[19:0]}, 32);
                check("start", starts, s + 1);
                check("req", op_req, {SFSP_KIND_SECTOR, am[19:0]});
                rdst(-1);
                check("poll", rd[1:0], 2'h3);
                done();
            end
            if (base[l] != `SFSP_BASE_NONE) begin
                s = starts;
                cmd({40'h0, WEN}, 8);
                cmd({8'h0, `SFSP_OP_PAGE_PROG, 4'h0, base[l][19:0], 8'h5A}, 40);
                check("blocked", starts, s);
                check("idle", status[0], 1'b0);
            end
        end
    endtask
    task automatic t_chip;
        int s;
        s = starts;
        cmd({40'h0, WEN}, 8);
        cmd({40'h0, `SFSP_OP_CHIP_ERASE_A}, 8);
        check("chip_refused", starts, s);
        wrst(8'h00);
        cmd({40'h0, WEN}, 8);
        cmd({40'h0, `SFSP_OP_CHIP_ERASE_B}, 8);
        check("chip_start", starts, s + 1);
        check("chip_kind", op_req.kind, SFSP_KIND_CHIP);
        done();
    endtask
    task automatic t_auto;
        wrst(8'h04);
        cmd({40'h0, WEN}, 8);
        cmd({`SFSP_OP_AUTO_INC, 24'h0EFFFC, 16'hA55A}, 48);
        check("auto_first", {status, op_req}, {8'h47, SFSP_KIND_AUTO_WORD, 20'hEFFFC});
        pulse_done();
        check("auto_mode", status, 8'h46);
        cmd({24'h0, `SFSP_OP_AUTO_INC, 16'hA55A}, 24);
        check("auto_next", op_req, {SFSP_KIND_AUTO_WORD, 20'hEFFFE});
        pulse_done();
        check("auto_end", status, 8'h04);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        bad_count++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge clk);
        #1 reset_n = 1'b1;
        cyc(4);
        t_reset();
        t_write();
        t_lock();
        t_write_disable_cmd();
        t_levels();
        t_chip();
        t_auto();
        conclude();
    end
endmodule
`default_nettype wire
